// file: tmr_params.svh
// Purpose: Offsets, field positions, reset values for the timer status block.
// Assumes: Byte-wide register port, 6-bit offsets.
// Notes: Included by the main module only; the package does not include it.
// Functional notes
// - Compare buffer-valid bit sets on buffer write, clears on UPDATE.
// - Period buffer-valid bit sets on period buffer write, clears on UPDATE.
// - Buffer-valid set register: ones set bits, zeros leave them.
// - Action 0 counts rising event edges; action 1 counts both edges.
// - Action 2 counts prescaled ticks while the event line is high.
// - Action 3 counts ticks, up when event low, down when high.
// - Event count enable bit gates event-driven counting.
// - Enable bits 4,5,6 enable compare interrupts of channels 0,1,2.
// - Enable bit 0 enables the wrap interrupt.
// - Compare flag sets when the running count equals the channel's compare value.
// - Compare flags clear only by writing one; zero has no effect.
// - Wrap flag sets at TOP or BOTTOM as the waveform mode selects.
// - Wrap flag stays set until software writes one to it.
// - Run bit 0: halted debug stops counting and ignores events.
// - Run bit 1: timer keeps running during halted debug.
// - One shared staging byte serves all 16-bit registers, also directly.
// - Low byte at base offset, high byte at base plus one.
// - Software write to the count beats a hardware count step.
// - Period register gives TOP outside frequency mode and resets to all ones.
// - On UPDATE, compare registers with a valid buffer load from it unless update is locked.
// - Buffer-valid clear register: ones clear bits, zeros leave them.
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH
`define TMR_OFS_BV_CLR 6'h06
`define TMR_OFS_BV_SET 6'h07
`define TMR_OFS_EVENT_CONTROL 6'h09
`define TMR_OFS_IRQ_EN 6'h0A
`define TMR_OFS_IRQ_FLAGS 6'h0B
`define TMR_OFS_DBG 6'h0E
`define TMR_OFS_STAGING 6'h0F
`define TMR_OFS_CNT_LO 6'h20
`define TMR_OFS_CNT_HI 6'h21
`define TMR_OFS_TOP_LO 6'h26
`define TMR_OFS_TOP_HI 6'h27
`define TMR_BIT_EVENT_COUNT_ENABLE 0
`define TMR_BIT_EVENT_ACTION_SELECT_LO 1
`define TMR_BIT_EVENT_ACTION_SELECT_HI 2
`define TMR_BIT_IRQ_WRAP 0
`define TMR_BIT_IRQ_M0 4
`define TMR_BIT_IRQ_M2 6
`define TMR_BIT_RUN_HALT 0
`define TMR_RST_BYTE 8'h00
`define TMR_RST_CNT 16'h0000
`define TMR_RST_TOP 16'hFFFF
`endif

// file: tmr_pkg.sv
// Purpose: Types shared by the timer status block.
// Assumes: Encodings follow the event action and waveform mode fields.
// Notes: Constants live in tmr_params.svh.
package tmr_pkg;
   typedef enum logic [1:0] {
      TMR_EV_POSEDGE = 2'h0,
      TMR_EV_ANYEDGE = 2'h1,
      TMR_EV_HIGHLVL = 2'h2,
      TMR_EV_UPDOWN = 2'h3
   } tmr_event_action_select_t;
   typedef enum logic [2:0] {
      TMR_WG_NORMAL = 3'h0,
      TMR_WG_FRQ = 3'h1,
      TMR_WG_SINGLE = 3'h3,
      TMR_WG_DSTOP = 3'h5,
      TMR_WG_DSBOTH = 3'h6,
      TMR_WG_DSBOTTOM = 3'h7
   } tmr_waveform_mode_t;
endpackage : tmr_pkg

// file: tmr_sticky.sv
// Purpose: Vector of sticky status bits with set and clear strobes.
// Assumes: Set and clear come from logic on the same clock.
// Notes: Set wins over clear so an event in the clearing cycle survives.
`timescale 1ns/10ps
module tmr_sticky #(
   parameter int WIDTH = 4
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] set_bits,
   input wire logic [WIDTH-1:0] clr_bits,
   output logic [WIDTH-1:0] q
);
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= (q & ~clr_bits) | set_bits;
      end
   end
endmodule : tmr_sticky

// file: tmr_regs.sv
// Purpose: Status, event counting, flags, staging byte, count and period registers.
// Assumes: Byte register port with one access per cycle; read data one cycle later.
// Notes: Compare registers, buffers and direction live outside this block.
`timescale 1ns/10ps
`include "tmr_params.svh"
module tmr_regs (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [5:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   input wire logic timer_enable,
   input wire logic prescale_tick,
   input wire logic count_down,
   input wire logic [2:0] waveform_mode,
   input wire logic update_lock,
   input wire logic cpu_halted,
   input wire logic event_in,
   input wire logic [2:0] compare_buffer_write,
   input wire logic top_buffer_write,
   input wire logic [15:0] top_buffer,
   input wire logic [15:0] match_value0,
   input wire logic [15:0] match_value1,
   input wire logic [15:0] match_value2,
   output logic [15:0] counter_value,
   output logic [15:0] top_value,
   output logic [3:0] buffer_valid,
   output logic [2:0] compare_load,
   output logic top_hit,
   output logic bottom_hit,
   output logic irq_wrap,
   output logic [2:0] irq_match
);
   logic [15:0] counter_value_reg;
   logic [15:0] counter_value_next;
   logic [15:0] top_value_reg;
   logic [7:0] staging_reg;
   logic [7:0] rdata_reg;
   logic event_count_enable_reg;
   tmr_pkg::tmr_event_action_select_t event_action_select_reg;
   logic run_while_halted_reg;
   logic [3:0] irq_enable_reg;
   logic [3:0] irq_out_reg;
   logic [2:0] compare_load_reg;
   logic top_hit_reg;
   logic bottom_hit_reg;
   logic ev_meta_reg;
   logic ev_sync_reg;
   logic ev_prev_reg;
   logic [3:0] bv_q;
   logic [3:0] bv_set;
   logic [3:0] bv_clr;
   logic [3:0] flag_q;
   logic [3:0] flag_set;
   logic [3:0] flag_clr;
   logic running;
   logic step;
   logic step_down;
   logic [15:0] cur_top;
   logic at_top;
   logic at_bottom;
   logic hit_top;
   logic hit_bottom;
   logic update_cond;
   logic wrap_cond;
   logic load_now;
   logic ev_rise;
   logic ev_fall;
   logic wr_cnt_hi;
   logic wr_top_hi;

   // Event input crosses from outside the clock domain.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ev_meta_reg <= 1'b0;
         ev_sync_reg <= 1'b0;
         ev_prev_reg <= 1'b0;
      end else begin
         ev_meta_reg <= event_in;
         ev_sync_reg <= ev_meta_reg;
         ev_prev_reg <= ev_sync_reg;
      end
   end

   assign ev_rise = ev_sync_reg & ~ev_prev_reg;
   assign ev_fall = ~ev_sync_reg & ev_prev_reg;

   // Halted debug freezes stepping unless the run bit is set, so edges seen meanwhile are dropped.
   assign running = timer_enable & (~cpu_halted | run_while_halted_reg);

   always_comb begin
      step = 1'b0;
      step_down = count_down;
      if (event_count_enable_reg) begin
         case (event_action_select_reg)
            tmr_pkg::TMR_EV_POSEDGE: step = ev_rise;
            tmr_pkg::TMR_EV_ANYEDGE: step = ev_rise | ev_fall;
            tmr_pkg::TMR_EV_HIGHLVL: step = prescale_tick & ev_sync_reg;
            tmr_pkg::TMR_EV_UPDOWN: begin
               step = prescale_tick;
               step_down = ev_sync_reg;
            end
            default: step = 1'b0;
         endcase
      end else begin
         step = prescale_tick;
      end
      if (!running) begin
         step = 1'b0;
      end
   end

   // Frequency mode takes TOP from channel 0, all other modes from the period.
   assign cur_top = (waveform_mode == tmr_pkg::TMR_WG_FRQ) ? match_value0 : top_value_reg;
   assign at_top = (counter_value_reg == cur_top);
   assign at_bottom = (counter_value_reg == 16'h0000);
   assign hit_top = step & ~step_down & at_top;
   assign hit_bottom = step & step_down & at_bottom;

   always_comb begin
      update_cond = 1'b0;
      wrap_cond = 1'b0;
      case (waveform_mode)
         tmr_pkg::TMR_WG_NORMAL, tmr_pkg::TMR_WG_FRQ: begin
            update_cond = hit_top;
            wrap_cond = hit_top;
         end
         tmr_pkg::TMR_WG_SINGLE, tmr_pkg::TMR_WG_DSBOTTOM: begin
            update_cond = hit_bottom;
            wrap_cond = hit_bottom;
         end
         tmr_pkg::TMR_WG_DSTOP: begin
            update_cond = hit_bottom;
            wrap_cond = hit_top;
         end
         tmr_pkg::TMR_WG_DSBOTH: begin
            update_cond = hit_top;
            wrap_cond = hit_top | hit_bottom;
         end
         default: begin
            update_cond = 1'b0;
            wrap_cond = 1'b0;
         end
      endcase
   end

   assign load_now = update_cond & ~update_lock;

   always_comb begin
      counter_value_next = counter_value_reg;
      if (step) begin
         if (step_down) begin
            counter_value_next = at_bottom ? cur_top : counter_value_reg - 16'h0001;
         end else begin
            counter_value_next = at_top ? 16'h0000 : counter_value_reg + 16'h0001;
         end
      end
   end

   assign wr_cnt_hi = bus_wr & (bus_addr == `TMR_OFS_CNT_HI);
   assign wr_top_hi = bus_wr & (bus_addr == `TMR_OFS_TOP_HI);

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         counter_value_reg <= `TMR_RST_CNT;
      end else if (wr_cnt_hi) begin
         counter_value_reg <= {bus_wdata, staging_reg};
      end else begin
         counter_value_reg <= counter_value_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         top_value_reg <= `TMR_RST_TOP;
      end else if (wr_top_hi) begin
         top_value_reg <= {bus_wdata, staging_reg};
      end else if (load_now && bv_q[0]) begin
         top_value_reg <= top_buffer;
      end
   end

   // Shared staging byte: low writes park here, low reads stage the high byte.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         staging_reg <= `TMR_RST_BYTE;
      end else if (bus_wr) begin
         case (bus_addr)
            `TMR_OFS_STAGING, `TMR_OFS_CNT_LO, `TMR_OFS_TOP_LO: begin
               staging_reg <= bus_wdata;
            end
            default: staging_reg <= staging_reg;
         endcase
      end else if (bus_rd) begin
         case (bus_addr)
            `TMR_OFS_CNT_LO: staging_reg <= counter_value_reg[15:8];
            `TMR_OFS_TOP_LO: staging_reg <= top_value_reg[15:8];
            default: staging_reg <= staging_reg;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         event_count_enable_reg <= 1'b0;
         event_action_select_reg <= tmr_pkg::TMR_EV_POSEDGE;
         irq_enable_reg <= 4'h0;
         run_while_halted_reg <= 1'b0;
      end else if (bus_wr) begin
         case (bus_addr)
            `TMR_OFS_EVENT_CONTROL: begin
               event_count_enable_reg <= bus_wdata[`TMR_BIT_EVENT_COUNT_ENABLE];
               event_action_select_reg <=
                  tmr_pkg::tmr_event_action_select_t'(bus_wdata[`TMR_BIT_EVENT_ACTION_SELECT_HI:`TMR_BIT_EVENT_ACTION_SELECT_LO]);
            end
            `TMR_OFS_IRQ_EN: begin
               irq_enable_reg <= {bus_wdata[`TMR_BIT_IRQ_M2:`TMR_BIT_IRQ_M0],
                                  bus_wdata[`TMR_BIT_IRQ_WRAP]};
            end
            `TMR_OFS_DBG: run_while_halted_reg <= bus_wdata[`TMR_BIT_RUN_HALT];
            default: run_while_halted_reg <= run_while_halted_reg;
         endcase
      end
   end

   // Buffer-valid bits: index 0 period, 1..3 compare channels 0..2.
   always_comb begin
      bv_set = {compare_buffer_write, top_buffer_write};
      bv_clr = {4{load_now}};
      if (bus_wr && bus_addr == `TMR_OFS_BV_SET) begin
         bv_set = bv_set | bus_wdata[3:0];
      end
      if (bus_wr && bus_addr == `TMR_OFS_BV_CLR) begin
         bv_clr = bv_clr | bus_wdata[3:0];
      end
   end

   tmr_sticky #(
      .WIDTH(4)
   ) u_buffer_valid (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .set_bits(bv_set),
      .clr_bits(bv_clr),
      .q(bv_q)
   );

   // Flags: index 0 wrap, 1..3 match channels 0..2; hardware never clears them.
   always_comb begin
      flag_set[0] = wrap_cond;
      flag_set[1] = running & (counter_value_reg == match_value0);
      flag_set[2] = running & (counter_value_reg == match_value1);
      flag_set[3] = running & (counter_value_reg == match_value2);
      flag_clr = 4'h0;
      if (bus_wr && bus_addr == `TMR_OFS_IRQ_FLAGS) begin
         flag_clr = {bus_wdata[`TMR_BIT_IRQ_M2:`TMR_BIT_IRQ_M0],
                     bus_wdata[`TMR_BIT_IRQ_WRAP]};
      end
   end

   tmr_sticky #(
      .WIDTH(4)
   ) u_flags (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .set_bits(flag_set),
      .clr_bits(flag_clr),
      .q(flag_q)
   );

   // Requests follow the flags one cycle late so every output is a flop.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         irq_out_reg <= 4'h0;
         compare_load_reg <= 3'h0;
         top_hit_reg <= 1'b0;
         bottom_hit_reg <= 1'b0;
      end else begin
         irq_out_reg <= flag_q & irq_enable_reg;
         compare_load_reg <= {3{load_now}} & bv_q[3:1];
         top_hit_reg <= hit_top;
         bottom_hit_reg <= hit_bottom;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rdata_reg <= `TMR_RST_BYTE;
      end else if (bus_rd) begin
         case (bus_addr)
            `TMR_OFS_BV_CLR, `TMR_OFS_BV_SET: rdata_reg <= {4'h0, bv_q};
            `TMR_OFS_EVENT_CONTROL: rdata_reg <= {5'h00, event_action_select_reg,
                                           event_count_enable_reg};
            `TMR_OFS_IRQ_EN: rdata_reg <= {1'b0, irq_enable_reg[3:1], 3'h0,
                                           irq_enable_reg[0]};
            `TMR_OFS_IRQ_FLAGS: rdata_reg <= {1'b0, flag_q[3:1], 3'h0, flag_q[0]};
            `TMR_OFS_DBG: rdata_reg <= {7'h00, run_while_halted_reg};
            `TMR_OFS_STAGING: rdata_reg <= staging_reg;
            `TMR_OFS_CNT_LO: rdata_reg <= counter_value_reg[7:0];
            `TMR_OFS_TOP_LO: rdata_reg <= top_value_reg[7:0];
            `TMR_OFS_CNT_HI, `TMR_OFS_TOP_HI: rdata_reg <= staging_reg;
            default: rdata_reg <= 8'h00;
         endcase
      end
   end

   assign bus_rdata = rdata_reg;
   assign counter_value = counter_value_reg;
   assign top_value = top_value_reg;
   assign buffer_valid = bv_q;
   assign compare_load = compare_load_reg;
   assign top_hit = top_hit_reg;
   assign bottom_hit = bottom_hit_reg;
   assign irq_wrap = irq_out_reg[0];
   assign irq_match = irq_out_reg[3:1];
endmodule : tmr_regs

// file: tmr_regs_asserts.sv
// Purpose: Port-level assertions for the timer status block.
// Assumes: Bound onto tmr_regs; count reads are judged only while the timer is stopped.
// Notes: Ports carry the design's names so the bind connects them by name.
`timescale 1ns/10ps
module tmr_regs_asserts (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [5:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   input wire logic timer_enable,
   input wire logic update_lock,
   input wire logic [2:0] compare_buffer_write,
   input wire logic [15:0] counter_value,
   input wire logic [15:0] top_value,
   input wire logic [3:0] buffer_valid,
   input wire logic [2:0] compare_load,
   input wire logic irq_wrap,
   input wire logic [2:0] irq_match
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   // A running count would move between the two reads, so the low read requires a stop.
   sequence lo_rd;
      bus_rd && bus_addr == 6'h20 && !timer_enable;
   endsequence
   sequence hi_rd;
      bus_rd && bus_addr == 6'h21;
   endsequence
   reset_vals_a: assert property (
      $rose(resetn) |-> top_value == 16'hFFFF && counter_value == 16'h0000)
      else $error("Outputs wrong after reset.");
   count_wins_a: assert property (
      bus_wr && bus_addr == 6'h21 |=> counter_value[15:8] == $past(bus_wdata))
      else $error("Count high byte write lost.");
   stopped_hold_a: assert property (
      !timer_enable && !(bus_wr && bus_addr == 6'h21) |=> $stable(counter_value))
      else $error("Count moved while stopped.");
   bv_set_a: assert property (
      |compare_buffer_write |=> (buffer_valid[3:1] & $past(compare_buffer_write))
         == $past(compare_buffer_write))
      else $error("Buffer valid not set on write.");
   load_valid_a: assert property (
      |compare_load |-> !$past(update_lock)
         && ((compare_load & $past(buffer_valid[3:1])) == compare_load))
      else $error("Compare load without valid buffer.");
   load_clears_a: assert property (
      |compare_load |-> (buffer_valid[3:1] & compare_load & ~$past(compare_buffer_write)) == 3'h0)
      else $error("Buffer valid kept after load.");
   hi_after_lo_a: assert property (
      lo_rd ##2 hi_rd |=> bus_rdata == $past(counter_value[15:8], 3))
      else $error("Staged high byte wrong.");
   irq_off_a: assert property (
      bus_wr && bus_addr == 6'h0A && bus_wdata == 8'h00 |=> ##1 !irq_wrap && irq_match == 3'h0)
      else $error("Interrupt stays up when disabled.");
endmodule : tmr_regs_asserts
bind tmr_regs tmr_regs_asserts tmr_regs_asserts_inst (
   .ref_clk(ref_clk),
   .resetn(resetn),
   .bus_addr(bus_addr),
   .bus_wr(bus_wr),
   .bus_rd(bus_rd),
   .bus_wdata(bus_wdata),
   .bus_rdata(bus_rdata),
   .timer_enable(timer_enable),
   .update_lock(update_lock),
   .compare_buffer_write(compare_buffer_write),
   .counter_value(counter_value),
   .top_value(top_value),
   .buffer_valid(buffer_valid),
   .compare_load(compare_load),
   .irq_wrap(irq_wrap),
   .irq_match(irq_match)
);

// file: tmr_regs_test.sv
// Purpose: Self-checking bench for the timer status block.
// Assumes: Inputs change on the falling edge; one bus access every other cycle.
// Notes: The period is set small so wrap and update are reached in a few ticks.
`timescale 1ns/10ps
module tmr_regs_test;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [5:0] bus_addr = 6'h00;
   logic [7:0] bus_wdata = 8'h00;
   logic [7:0] bus_rdata;
   logic bus_wr = 1'b0, bus_rd = 1'b0, timer_enable = 1'b0, prescale_tick = 1'b0;
   logic count_down = 1'b0, update_lock = 1'b0, cpu_halted = 1'b0, event_in = 1'b0;
   logic top_buffer_write = 1'b0, wr_tick = 1'b0, top_hit, bottom_hit, irq_wrap;
   logic [2:0] waveform_mode = 3'h0, compare_buffer_write = 3'h0, compare_load, irq_match;
   logic [15:0] top_buffer = 16'h0030, counter_value, top_value;
   logic [15:0] match_value0, match_value1, match_value2;
   logic [47:0] mvs = {16'h8002, 16'h8001, 16'h8000};
   logic [3:0] buffer_valid;
   logic [5:0] ra [12] = '{6'h06, 6'h07, 6'h09, 6'h0A, 6'h0B, 6'h0E, 6'h0F, 6'h20, 6'h21,
      6'h26, 6'h27, 6'h10};
   logic [21:0] rw_tab [5] = '{{6'h09, 8'hFF, 8'h07}, {6'h0A, 8'hFF, 8'h71},
      {6'h0E, 8'hFF, 8'h01}, {6'h0F, 8'hA5, 8'hA5}, {6'h10, 8'hFF, 8'h00}};
   logic [2:0] md [4] = '{3'h1, 3'h5, 3'h6, 3'h7};
   logic [7:0] fl_up [4] = '{8'h11, 8'h01, 8'h01, 8'h00};
   logic [7:0] fl_dn [4] = '{8'h10, 8'h00, 8'h01, 8'h01};
   int n_fail = 0, cmp_count = 0, n_load = 0, n_top = 0, n_bot = 0;
   assign match_value0 = mvs[15:0];
   assign match_value1 = mvs[31:16];
   assign match_value2 = mvs[47:32];
   tmr_regs tmr_regs_inst (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .bus_addr(bus_addr),
      .bus_wr(bus_wr),
      .bus_rd(bus_rd),
      .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata),
      .timer_enable(timer_enable),
      .prescale_tick(prescale_tick),
      .count_down(count_down),
      .waveform_mode(waveform_mode),
      .update_lock(update_lock),
      .cpu_halted(cpu_halted),
      .event_in(event_in),
      .compare_buffer_write(compare_buffer_write),
      .top_buffer_write(top_buffer_write),
      .top_buffer(top_buffer),
      .match_value0(match_value0),
      .match_value1(match_value1),
      .match_value2(match_value2),
      .counter_value(counter_value),
      .top_value(top_value),
      .buffer_valid(buffer_valid),
      .compare_load(compare_load),
      .top_hit(top_hit),
      .bottom_hit(bottom_hit),
      .irq_wrap(irq_wrap),
      .irq_match(irq_match)
   );
   always #25 ref_clk = ~ref_clk;
   // Pulse outputs are counted, so a check only needs to come after the pulse.
   always @(posedge ref_clk) begin
      if (compare_load[0])
         n_load <= n_load + 1;
      if (top_hit)
         n_top <= n_top + 1;
      if (bottom_hit)
         n_bot <= n_bot + 1;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      prescale_tick = wr_tick;
      @(negedge ref_clk);
      bus_wr = 1'b0;
      prescale_tick = 1'b0;
   endtask : wr
   task automatic rc(input logic [5:0] a, input logic [7:0] e);
      @(negedge ref_clk);
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge ref_clk);
      bus_rd = 1'b0;
      chk(bus_rdata, e);
   endtask : rc
   task automatic setc(input logic [15:0] v);
      wr(6'h20, v[7:0]);
      wr(6'h21, v[15:8]);
   endtask : setc
   task automatic tk(input int n);
      repeat (n) begin
         @(negedge ref_clk);
         prescale_tick = 1'b1;
         @(negedge ref_clk);
         prescale_tick = 1'b0;
      end
   endtask : tk
   // The event line passes a synchroniser, so each change is given four cycles to act.
   task automatic ev(input int n);
      repeat (n) begin
         @(negedge ref_clk);
         event_in = ~event_in;
         repeat (4) @(negedge ref_clk);
      end
   endtask : ev
   task automatic chkc(input logic [15:0] e);
      repeat (2) @(negedge ref_clk);
      chk(counter_value, e);
   endtask : chkc
   task automatic bw(input logic [2:0] c, input logic t);
      @(negedge ref_clk);
      compare_buffer_write = c;
      top_buffer_write = t;
      @(negedge ref_clk);
      compare_buffer_write = 3'h0;
      top_buffer_write = 1'b0;
   endtask : bw
   task automatic complete_run();
      if (n_fail == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   initial begin
      repeat (2) @(negedge ref_clk);
      resetn = 1'b1;
      chk(top_value, 16'hFFFF);
      foreach (ra[i]) rc(ra[i], (ra[i][5:1] == 5'h13) ? 8'hFF : 8'h00);
      foreach (rw_tab[i]) begin
         wr(rw_tab[i][21:16], rw_tab[i][15:8]);
         rc(rw_tab[i][21:16], rw_tab[i][7:0]);
      end
      wr(6'h09, 8'h00);
      wr(6'h0A, 8'h00);
      wr(6'h0E, 8'h00);
      setc(16'h1234);
      chk(counter_value, 16'h1234);
      rc(6'h20, 8'h34);
      rc(6'h21, 8'h12);
      rc(6'h0F, 8'h12);
      wr(6'h26, 8'h20);
      wr(6'h27, 8'h00);
      chk(top_value, 16'h0020);
      bw(3'h5, 1'b1);
      rc(6'h07, 8'h0B);
      wr(6'h06, 8'h09);
      rc(6'h06, 8'h02);
      wr(6'h07, 8'h05);
      rc(6'h07, 8'h07);
      timer_enable = 1'b1;
      setc(16'h0010);
      tk(5);
      chkc(16'h0015);
      count_down = 1'b1;
      tk(2);
      chkc(16'h0013);
      count_down = 1'b0;
      for (int ch = 0; ch < 3; ch++) begin
         mvs[ch*16 +: 16] = 16'h0015;
         setc(16'h0014);
         tk(2);
         mvs[ch*16 +: 16] = 16'h8000;
         wr(6'h0B, 8'h00);
         rc(6'h0B, 8'h10 << ch);
         wr(6'h0A, 8'h10 << ch);
         repeat (2) @(negedge ref_clk);
         chk(irq_match, 3'h1 << ch);
         wr(6'h0B, 8'h10 << ch);
         rc(6'h0B, 8'h00);
         wr(6'h0A, 8'h00);
      end
      setc(16'h001F);
      tk(2);
      chkc(16'h0000);
      chk(top_value, 16'h0030);
      chk(n_load, 1);
      rc(6'h07, 8'h00);
      rc(6'h0B, 8'h01);
      wr(6'h0A, 8'h01);
      repeat (2) @(negedge ref_clk);
      chk(irq_wrap, 1'b1);
      wr(6'h0B, 8'h00);
      rc(6'h0B, 8'h01);
      wr(6'h0B, 8'h01);
      rc(6'h0B, 8'h00);
      update_lock = 1'b1;
      bw(3'h1, 1'b0);
      setc(16'h002F);
      tk(2);
      // The read gives a stray load time to reach the counter before it is judged.
      rc(6'h07, 8'h02);
      chk(n_load, 1);
      update_lock = 1'b0;
      wr(6'h0B, 8'h01);
      waveform_mode = 3'h3;
      count_down = 1'b1;
      setc(16'h0001);
      tk(2);
      chkc(16'h0030);
      rc(6'h0B, 8'h01);
      chk(n_top, 2);
      chk(n_bot, 1);
      count_down = 1'b0;
      waveform_mode = 3'h0;
      wr(6'h20, 8'h00);
      wr_tick = 1'b1;
      wr(6'h21, 8'h07);
      wr_tick = 1'b0;
      chkc(16'h0700);
      setc(16'h0005);
      cpu_halted = 1'b1;
      tk(3);
      chkc(16'h0005);
      wr(6'h0E, 8'h01);
      tk(3);
      chkc(16'h0008);
      cpu_halted = 1'b0;
      wr(6'h0E, 8'h00);
      setc(16'h0000);
      wr(6'h09, 8'h01);
      ev(6);
      chkc(16'h0003);
      wr(6'h09, 8'h03);
      ev(4);
      tk(2);
      chkc(16'h0007);
      wr(6'h09, 8'h05);
      tk(2);
      ev(1);
      tk(3);
      chkc(16'h000A);
      wr(6'h09, 8'h07);
      tk(2);
      ev(1);
      tk(3);
      chkc(16'h000B);
      // Remaining modes: frequency mode takes TOP from channel 0, set apart from the period.
      wr(6'h09, 8'h00);
      mvs[15:0] = 16'h0020;
      for (int i = 0; i < 4; i++) begin
         waveform_mode = md[i];
         bw(3'h1, 1'b0);
         setc((md[i] == 3'h1) ? 16'h001F : 16'h002F);
         wr(6'h0B, 8'h71);
         tk(2);
         rc(6'h0B, fl_up[i]);
         rc(6'h07, (md[i] == 3'h1 || md[i] == 3'h6) ? 8'h00 : 8'h02);
         count_down = 1'b1;
         setc(16'h0001);
         wr(6'h0B, 8'h71);
         tk(2);
         rc(6'h0B, fl_dn[i]);
         chk(n_load, 3 + i);
         count_down = 1'b0;
      end
      complete_run();
   end
endmodule : tmr_regs_test
